// ==== rtl/idb_defs.svh ====
`ifndef IDB_DEFS_SVH
`define IDB_DEFS_SVH
// apb register map (byte addresses)
`define IDB_ADDR_CTRL 12'h000
`define IDB_ADDR_INSTR 12'h004
`define IDB_ADDR_OPERAND 12'h008
`define IDB_ADDR_STATE 12'h00c
`define IDB_ADDR_INDEX 12'h010
`define IDB_ADDR_PC 12'h014
`define IDB_ADDR_STATUS 12'h018
`define IDB_ADDR_MEMDATA 12'h01c
`define IDB_ADDR_MEMRD 12'h020
`define IDB_ADDR_MEMWR 12'h024
// state register fields
`define IDB_ST_ACC_LSB 0
`define IDB_ST_CARRY_BIT 4
`define IDB_ST_SKIP_BIT 5
// status fields
`define IDB_STS_SP_LSB 0
`define IDB_STS_WR_BIT 4
`define IDB_STS_INC_BIT 5
// correction constants
`define IDB_DAA_CORR 4'h6
`define IDB_DAS_CORR 4'ha
`define IDB_BCD_MAX 4'h9
`define IDB_DAA_CARRY_MAX 4'h3
`define IDB_DAS_MIN 4'h6
`define IDB_STACK_DEPTH 8
`endif

// ==== rtl/idb_pkg.sv ====
package idb_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_LOAD_INDEX_UPPER, OP_LOAD_INDEX_HIGH, OP_LOAD_INDEX_LOW,
      OP_INDEX_COMPARE_SKIP, OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB,
      OP_BRANCH_ACC_BIT0, OP_BRANCH_ACC_BIT1, OP_BRANCH_ACC_BIT2, OP_BRANCH_ACC_BIT3,
      OP_BRANCH_NOT_ZERO, OP_BRANCH_ZERO, OP_BRANCH_NO_CARRY, OP_BRANCH_CARRY,
      OP_JUMP_FAR, OP_CALL, OP_RETURN
   } idb_op_t;
   // store: 0 none, 1 to data nibble; incr: bump index afterwards
   typedef struct packed {
      idb_op_t op;
      logic store;
      logic incr;
   } idb_instr_t;
   typedef struct packed {
      logic [11:0] pc;
      logic [11:0] index;
      logic [3:0] acc;
      logic carry;
   } idb_core_t;
endpackage

// ==== rtl/idb_bcd.sv ====
`timescale 1ns/1ps
`include "idb_defs.svh"
module idb_bcd
   import idb_pkg::*;
(
   // operands
   input wire logic sub,
   input wire logic [3:0] acc_in,
   input wire logic carry_in,
   // result
   output logic [3:0] acc_out,
   output logic carry_out
);
   wire add_hi = !sub && !carry_in && (acc_in > `IDB_BCD_MAX);
   wire add_lo = !sub && carry_in && (acc_in <= `IDB_DAA_CARRY_MAX);
   wire sub_fix = sub && !carry_in && (acc_in >= `IDB_DAS_MIN);
   assign acc_out = add_hi || add_lo ? 4'(acc_in + `IDB_DAA_CORR) :
                    sub_fix ? 4'(acc_in + `IDB_DAS_CORR) : acc_in;
   assign carry_out = add_hi ? 1'b1 : carry_in;
endmodule

// ==== rtl/idb_stack.sv ====
`timescale 1ns/1ps
module idb_stack
   import idb_pkg::*;
#(
   parameter int DEPTH = 8,
   parameter int AW = 12
)(
   // clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // push and pop
   input wire logic push,
   input wire logic pop,
   input wire logic [AW-1:0] push_data,
   output logic [AW-1:0] top,
   output logic [$clog2(DEPTH):0] level
);
   logic [AW-1:0] mem [DEPTH];
   logic [$clog2(DEPTH)-1:0] sp;
   wire [$clog2(DEPTH)-1:0] sp_top = sp - 1'b1;
   // overflow wraps and overwrites the oldest entry
   assign top = mem[sp_top];
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         sp <= '0;
         level <= '0;
      end else if (push) begin
         sp <= sp + 1'b1;
         if (level != DEPTH[$clog2(DEPTH):0]) level <= level + 1'b1;
      end else if (pop) begin
         sp <= sp_top;
         if (level != '0) level <= level - 1'b1;
      end
   end
   always_ff @(posedge MCLK) begin
      if (push) mem[sp] <= push_data;
   end
endmodule

// ==== rtl/idb_exec.sv ====
`timescale 1ns/1ps
`include "idb_defs.svh"
// Summary of operation
// - index load copies the addressed data nibble into upper, high or low buffer.
// - compare high/low index with 8-bit immediate; match turns next instruction into no-op.
// - add adjust: A-F with carry clear adds 6, sets carry; 0-3 carry set adds 6.
// - subtract adjust: 0-9 carry set unchanged; 6-F carry clear adds A; carry kept.
// - adjust with operand stores result to data nibble; increment variant bumps index.
// - accumulator bit branches jump inside current 2K page, else pc plus one.
// - zero branches jump in page on nonzero or zero, else pc plus one.
// - carry branches jump in page on clear or set carry, else pc plus one.
// - far jump loads any address of the 4K program space.
// - call pushes pc plus one then loads any 4K target.
// - return pops the stack top into the pc.
module idb_exec
   import idb_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // data memory port
   output logic [11:0] MEM_ADDR,
   output logic MEM_WE,
   output logic [3:0] MEM_WDATA
);
   idb_core_t core;
   idb_instr_t instr;
   logic [11:0] operand;
   logic [3:0] mem_rdata;
   logic skip;
   logic [31:0] rdata;
   logic [3:0] mem_wdata_q;
   logic [11:0] mem_addr_q;
   logic mem_we_q;

   wire apb_acc = PSEL && PENABLE;
   wire apb_wr = apb_acc && PWRITE;
   wire hit_instr = PADDR == `IDB_ADDR_INSTR;
   wire hit_operand = PADDR == `IDB_ADDR_OPERAND;
   wire hit_state = PADDR == `IDB_ADDR_STATE;
   wire hit_index = PADDR == `IDB_ADDR_INDEX;
   wire hit_pc = PADDR == `IDB_ADDR_PC;
   wire hit_status = PADDR == `IDB_ADDR_STATUS;
   wire hit_memdata = PADDR == `IDB_ADDR_MEMDATA;
   wire hit_ctrl = PADDR == `IDB_ADDR_CTRL;
   wire hit_any = hit_instr | hit_operand | hit_state | hit_index | hit_pc | hit_status | hit_memdata | hit_ctrl;
   // writing the ctrl register with bit 0 executes the staged instruction
   wire exec = apb_wr && hit_ctrl && PWDATA[0];

   // execution
   logic [3:0] bcd_acc;
   logic bcd_carry;
   logic [11:0] stack_top;
   logic [3:0] stack_level;
   wire is_daa = instr.op == OP_DECIMAL_ADJUST_ADD;
   wire is_das = instr.op == OP_DECIMAL_ADJUST_SUB;
   wire do_op = exec && !skip;

   idb_bcd idb_bcd_inst (
      .sub(is_das),
      .acc_in(core.acc),
      .carry_in(core.carry),
      .acc_out(bcd_acc),
      .carry_out(bcd_carry)
   );

   wire [11:0] pc_inc = 12'(core.pc + 12'h001);
   wire [11:0] page_target = {core.pc[11], operand[10:0]};
   logic cond_true;
   always_comb begin
      unique case (instr.op)
         OP_BRANCH_ACC_BIT0: cond_true = core.acc[0];
         OP_BRANCH_ACC_BIT1: cond_true = core.acc[1];
         OP_BRANCH_ACC_BIT2: cond_true = core.acc[2];
         OP_BRANCH_ACC_BIT3: cond_true = core.acc[3];
         OP_BRANCH_NOT_ZERO: cond_true = core.acc != 4'h0;
         OP_BRANCH_ZERO: cond_true = core.acc == 4'h0;
         OP_BRANCH_NO_CARRY: cond_true = !core.carry;
         OP_BRANCH_CARRY: cond_true = core.carry;
         default: cond_true = 1'b0;
      endcase
   end
   wire is_cond = instr.op inside {OP_BRANCH_ACC_BIT0, OP_BRANCH_ACC_BIT1, OP_BRANCH_ACC_BIT2,
      OP_BRANCH_ACC_BIT3, OP_BRANCH_NOT_ZERO, OP_BRANCH_ZERO, OP_BRANCH_NO_CARRY, OP_BRANCH_CARRY};
   wire push = do_op && instr.op == OP_CALL;
   wire pop = do_op && instr.op == OP_RETURN;

   idb_stack #(.DEPTH(`IDB_STACK_DEPTH), .AW(12)) idb_stack_inst (
      .MCLK(MCLK),
      .NRST(NRST),
      .push(push),
      .pop(pop),
      .push_data(pc_inc),
      .top(stack_top),
      .level(stack_level)
   );

   logic [11:0] next_pc;
   always_comb begin
      next_pc = pc_inc;
      if (do_op) begin
         if (is_cond && cond_true) next_pc = page_target;
         else if (instr.op == OP_JUMP_FAR || instr.op == OP_CALL) next_pc = operand;
         else if (instr.op == OP_RETURN) next_pc = stack_top;
      end
   end

   wire idx_match = core.index[7:0] == operand[7:0];
   wire adj_store = do_op && (is_daa || is_das) && instr.store;
   wire adj_incr = do_op && (is_daa || is_das) && instr.incr;

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         core <= '0;
         skip <= 1'b0;
      end else if (exec) begin
         core.pc <= next_pc;
         skip <= do_op && instr.op == OP_INDEX_COMPARE_SKIP && idx_match;
         if (do_op && (is_daa || is_das)) begin
            core.acc <= bcd_acc;
            core.carry <= bcd_carry;
         end
         if (adj_incr) core.index[7:0] <= 8'(core.index[7:0] + 8'h01);
         else if (do_op && instr.op == OP_LOAD_INDEX_UPPER) core.index[11:8] <= mem_rdata;
         else if (do_op && instr.op == OP_LOAD_INDEX_HIGH) core.index[7:4] <= mem_rdata;
         else if (do_op && instr.op == OP_LOAD_INDEX_LOW) core.index[3:0] <= mem_rdata;
      end else if (apb_wr) begin
         if (hit_state) begin
            core.acc <= PWDATA[`IDB_ST_ACC_LSB +: 4];
            core.carry <= PWDATA[`IDB_ST_CARRY_BIT];
         end
         if (hit_index) core.index <= PWDATA[11:0];
         if (hit_pc) core.pc <= PWDATA[11:0];
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         instr <= '{op: OP_NOP, store: 1'b0, incr: 1'b0};
         operand <= '0;
         mem_rdata <= '0;
      end else if (apb_wr) begin
         if (hit_instr) begin
            instr.op <= idb_op_t'(PWDATA[4:0]);
            instr.store <= PWDATA[8];
            instr.incr <= PWDATA[9];
         end
         if (hit_operand) operand <= PWDATA[11:0];
         if (hit_memdata) mem_rdata <= PWDATA[3:0];
      end
   end

   // adjusted nibble goes to the index-addressed data nibble (or operand address when incr clear)
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         mem_we_q <= 1'b0;
         mem_wdata_q <= '0;
         mem_addr_q <= '0;
      end else begin
         mem_we_q <= adj_store;
         if (adj_store) begin
            mem_wdata_q <= bcd_acc;
            mem_addr_q <= instr.incr ? core.index : operand;
         end
      end
   end
   assign MEM_WE = mem_we_q;
   assign MEM_WDATA = mem_wdata_q;
   assign MEM_ADDR = mem_addr_q;

   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_instr) rdata = {22'h0, instr.incr, instr.store, 3'h0, instr.op};
      if (hit_operand) rdata = {20'h0, operand};
      if (hit_state) rdata = {26'h0, skip, core.carry, core.acc};
      if (hit_index) rdata = {20'h0, core.index};
      if (hit_pc) rdata = {20'h0, core.pc};
      if (hit_status) rdata = {28'h0, stack_level};
      if (hit_memdata) rdata = {28'h0, mem_rdata};
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) PRDATA <= '0;
      else if (PSEL && !PENABLE && !PWRITE) PRDATA <= rdata;
   end
   assign PREADY = 1'b1;
   assign PSLVERR = apb_acc && !hit_any;

   property p_skip;
      @(posedge MCLK) disable iff (!NRST)
      (exec && !skip && instr.op == OP_INDEX_COMPARE_SKIP && idx_match) |=> skip;
   endproperty
   AST_CMP_SKIP: assert property (p_skip) else $error("compare match did not arm skip");
   AST_SKIP_PC: assert property (@(posedge MCLK) disable iff (!NRST)
      (exec && skip) |=> core.pc == $past(pc_inc)) else $error("skipped op did not advance pc");
   AST_SKIP_ACC: assert property (@(posedge MCLK) disable iff (!NRST)
      (exec && skip) |=> $stable(core.acc) && $stable(core.carry)) else $error("skipped op changed acc");
   AST_DAA_HI: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_daa && !core.carry && core.acc > 4'h9) |=> core.carry && core.acc == 4'($past(core.acc) + 4'h6))
      else $error("add adjust high case wrong");
   AST_DAS_KEEP: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_das && core.carry && core.acc <= 4'h9) |=> $stable(core.acc) && core.carry)
      else $error("sub adjust changed valid value");
   AST_JFAR: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_JUMP_FAR) |=> core.pc == $past(operand)) else $error("far jump target wrong");
   sequence s_call;
      do_op && instr.op == OP_CALL;
   endsequence
   AST_CALL_RET: assert property (@(posedge MCLK) disable iff (!NRST)
      s_call |=> stack_top == $past(pc_inc)) else $error("call pushed wrong address");
   AST_BR_PAGE: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_cond && cond_true) |=> core.pc[11] == $past(core.pc[11]))
      else $error("branch left its page");
   AST_STORE: assert property (@(posedge MCLK) disable iff (!NRST)
      adj_store |=> MEM_WE && MEM_WDATA == $past(bcd_acc)) else $error("adjust store missing");

   // step sequences shared by the branch and adjust checks
   sequence s_adjust;
      do_op && (is_daa || is_das);
   endsequence
   sequence s_taken;
      do_op && is_cond && cond_true;
   endsequence
   sequence s_not_taken;
      do_op && is_cond && !cond_true;
   endsequence

   // index buffer loads touch only their own nibble
   AST_LD_UPPER: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_LOAD_INDEX_UPPER) |=> core.index == {$past(mem_rdata), $past(core.index[7:0])})
      else $error("upper index load wrong");
   AST_LD_HIGH: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_LOAD_INDEX_HIGH) |=> core.index[7:4] == $past(mem_rdata))
      else $error("high index load wrong");
   AST_LD_HIGH_KEEP: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_LOAD_INDEX_HIGH) |=> core.index[11:8] == $past(core.index[11:8]))
      else $error("high index load disturbed upper");
   AST_LD_LOW: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_LOAD_INDEX_LOW) |=> core.index == {$past(core.index[11:4]), $past(mem_rdata)})
      else $error("low index load wrong");

   // compare never alters state beyond the skip flag and the pc advance
   AST_CMP_NOSKIP: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_INDEX_COMPARE_SKIP && !idx_match) |=> !skip)
      else $error("compare mismatch armed skip");
   AST_CMP_STATE: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_INDEX_COMPARE_SKIP) |=> $stable(core.index) && $stable(core.acc))
      else $error("compare changed state");
   AST_SKIP_CLEAR: assert property (@(posedge MCLK) disable iff (!NRST)
      (exec && skip) |=> !skip)
      else $error("skip flag not consumed");
   AST_SKIP_NOSTORE: assert property (@(posedge MCLK) disable iff (!NRST)
      (exec && skip) |=> !MEM_WE && $stable(core.index))
      else $error("skipped op touched memory or index");

   // decimal correction cases
   AST_DAA_LO: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_daa && core.carry && core.acc <= 4'h3) |=> core.carry && core.acc == 4'($past(core.acc) + 4'h6))
      else $error("add adjust low case wrong");
   AST_DAA_KEEP: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_daa && !core.carry && core.acc <= 4'h9) |=> $stable(core.acc) && !core.carry)
      else $error("add adjust changed valid value");
   AST_DAS_FIX: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_das && !core.carry && core.acc >= 4'h6) |=> !core.carry && core.acc == 4'($past(core.acc) + 4'ha))
      else $error("sub adjust fix case wrong");
   AST_DAS_CARRY: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_das) |=> $stable(core.carry))
      else $error("sub adjust moved carry");

   // only the low byte of the index counts; the upper nibble never carries in
   AST_ADJ_INCR: assert property (@(posedge MCLK) disable iff (!NRST)
      adj_incr |=> core.index == {$past(core.index[11:8]), 8'($past(core.index[7:0]) + 8'h01)})
      else $error("index not bumped");
   AST_ADJ_NOINCR: assert property (@(posedge MCLK) disable iff (!NRST)
      (s_adjust ##0 !instr.incr) |=> $stable(core.index))
      else $error("index bumped without increment variant");
   AST_STORE_ADDR: assert property (@(posedge MCLK) disable iff (!NRST)
      (adj_store && instr.incr) |=> MEM_ADDR == $past(core.index))
      else $error("store went to wrong nibble");
   AST_STORE_OPND: assert property (@(posedge MCLK) disable iff (!NRST)
      (adj_store && !instr.incr) |=> MEM_ADDR == $past(operand))
      else $error("store went to wrong operand nibble");
   AST_NO_STORE: assert property (@(posedge MCLK) disable iff (!NRST)
      !adj_store |=> !MEM_WE)
      else $error("stray nibble store");
   // a ctrl write needs its own setup cycle, so two stores can never abut
   AST_STORE_ONE: assert property (@(posedge MCLK) disable iff (!NRST)
      MEM_WE |=> !MEM_WE)
      else $error("store pulse too long");

   // branches
   AST_BR_TAKEN: assert property (@(posedge MCLK) disable iff (!NRST)
      s_taken |=> core.pc == {$past(core.pc[11]), $past(operand[10:0])})
      else $error("taken branch target wrong");
   AST_BR_NOT: assert property (@(posedge MCLK) disable iff (!NRST)
      s_not_taken |=> core.pc == $past(pc_inc))
      else $error("untaken branch did not advance");
   AST_BR_FLAGS: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && is_cond) |=> $stable(core.acc) && $stable(core.carry) && $stable(core.index))
      else $error("branch changed state");
   AST_BIT0: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_ACC_BIT0) |-> cond_true == core.acc[0])
      else $error("bit0 branch condition wrong");
   AST_BIT3: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_ACC_BIT3) |-> cond_true == core.acc[3])
      else $error("bit3 branch condition wrong");
   AST_NZ: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_NOT_ZERO) |-> cond_true == (core.acc != 4'h0))
      else $error("nonzero branch condition wrong");
   AST_Z: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_ZERO) |-> cond_true == (core.acc == 4'h0))
      else $error("zero branch condition wrong");
   AST_NC: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_NO_CARRY) |-> cond_true == !core.carry)
      else $error("no-carry branch condition wrong");
   AST_C: assert property (@(posedge MCLK) disable iff (!NRST)
      (do_op && instr.op == OP_BRANCH_CARRY) |-> cond_true == core.carry)
      else $error("carry branch condition wrong");

   // call and return
   AST_CALL_PC: assert property (@(posedge MCLK) disable iff (!NRST)
      s_call |=> core.pc == $past(operand))
      else $error("call target wrong");
   AST_CALL_LVL: assert property (@(posedge MCLK) disable iff (!NRST)
      (push && stack_level < 4'h8) |=> stack_level == 4'($past(stack_level) + 4'h1))
      else $error("call did not deepen stack");
   AST_RET_PC: assert property (@(posedge MCLK) disable iff (!NRST)
      pop |=> core.pc == $past(stack_top))
      else $error("return address wrong");
   AST_RET_LVL: assert property (@(posedge MCLK) disable iff (!NRST)
      (pop && stack_level != 4'h0) |=> stack_level == 4'($past(stack_level) - 4'h1))
      else $error("return did not shrink stack");
   // overflow overwrites the oldest entry, so the level saturates at the depth
   AST_LVL_MAX: assert property (@(posedge MCLK) disable iff (!NRST)
      stack_level <= 4'h8)
      else $error("stack level beyond depth");

   // without an execute or a pc write the program counter rests
   AST_PC_HOLD: assert property (@(posedge MCLK) disable iff (!NRST)
      (!exec && !(apb_wr && hit_pc)) |=> $stable(core.pc))
      else $error("pc moved while idle");
endmodule

// ==== verification/idb_mem_model.sv ====
`timescale 1ns/1ps
module idb_mem_model (
   // clock
   input wire logic MCLK,
   // nibble writes from the block
   input wire logic [11:0] MEM_ADDR,
   input wire logic MEM_WE,
   input wire logic [3:0] MEM_WDATA,
   // lookup used to stage the addressed nibble
   input wire logic [11:0] rd_addr,
   output logic [3:0] rd_data
);
   logic [3:0] mem [4096];
   // a fixed fill, so that every address holds a known nibble before the first store
   initial begin
      foreach (mem[i]) begin
         mem[i] = 4'(i * 7 + 3);
      end
   end
   assign rd_data = mem[rd_addr];
   always @(posedge MCLK) begin
      if (MEM_WE === 1'b1) begin
         mem[MEM_ADDR] <= MEM_WDATA;
      end
   end
endmodule

// ==== verification/index_decimal_branch_exec_tb_top.sv ====
`timescale 1ns/1ps
`include "idb_defs.svh"
module index_decimal_branch_exec_tb_top;
   import idb_pkg::*;
   logic MCLK = 1'b0;
   logic NRST = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, MEM_WE, err, c, tk;
   logic [11:0] MEM_ADDR, pc, idx;
   logic [3:0] MEM_WDATA, peek_data, a;
   logic [11:0] peek_addr = 12'h000;
   logic [31:0] lfsr = 32'hba886cb9;
   logic [31:0] rd_q[$];
   logic [15:0] wr_q[$];
   logic [11:0] ret_pc[8];
   // digits: sub, acc, carry, expected acc, expected carry
   logic [19:0] tab[11] = '{20'h05050, 20'h0c021, 20'h02181, 20'h07171, 20'h09090, 20'h0a001,
      20'h15151, 20'h1c060, 20'h17010, 20'h19191, 20'h16000};
   int fail_count = 0;
   int cmp_count = 0;
   always #5 MCLK = ~MCLK;
   idb_exec idb_exec_inst (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA));
   idb_mem_model idb_mem_model_inst (.MCLK(MCLK), .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE),
      .MEM_WDATA(MEM_WDATA), .rd_addr(peek_addr), .rd_data(peek_data));
   function automatic logic [31:0] step(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one idle cycle after each transfer keeps a select from being driven twice in one step
   task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(logic [11:0] ad, logic [31:0] e);
      rd_q.push_back(e);
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic put(logic [11:0] p, logic [11:0] x, logic [3:0] ac, logic cy);
      apb(1'b1, `IDB_ADDR_PC, {20'h0, p});
      apb(1'b1, `IDB_ADDR_INDEX, {20'h0, x});
      apb(1'b1, `IDB_ADDR_STATE, {27'h0, cy, ac});
   endtask
   task automatic look(logic [11:0] p, logic [11:0] x, logic [3:0] ac, logic cy, logic sk);
      rd(`IDB_ADDR_PC, {20'h0, p});
      rd(`IDB_ADDR_INDEX, {20'h0, x});
      rd(`IDB_ADDR_STATE, {26'h0, sk, cy, ac});
   endtask
   task automatic ex(idb_op_t op, logic st, logic inc, logic [11:0] opd);
      apb(1'b1, `IDB_ADDR_INSTR, {22'h0, inc, st, 3'h0, op});
      apb(1'b1, `IDB_ADDR_OPERAND, {20'h0, opd});
      apb(1'b1, `IDB_ADDR_CTRL, 32'h1);
   endtask
   always @(posedge MCLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
         chk("read data", PRDATA, rd_q.pop_front());
      end
      if (MEM_WE === 1'b1) begin
         chk("nibble store", {16'h0, MEM_ADDR, MEM_WDATA}, {16'h0, wr_q.pop_front()});
      end
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge MCLK);
      NRST <= 1'b1;
      @(posedge MCLK);
      look(12'h000, 12'h000, 4'h0, 1'b0, 1'b0);
      rd(`IDB_ADDR_STATUS, 32'h0);
      rd(12'hffc, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      idx = 12'h000;
      for (int k = 0; k < 3; k++) begin
         lfsr = step(lfsr);
         peek_addr <= lfsr[11:0];
         @(posedge MCLK);
         apb(1'b1, `IDB_ADDR_MEMDATA, {28'h0, peek_data});
         ex(idb_op_t'(k + 1), 1'b0, 1'b0, peek_addr);
         idx[11 - 4 * k -: 4] = peek_data;
      end
      look(12'h003, idx, 4'h0, 1'b0, 1'b0);
      put(12'h010, idx, 4'hc, 1'b0);
      ex(OP_INDEX_COMPARE_SKIP, 1'b0, 1'b0, {~idx[11:8], idx[7:0]});
      look(12'h011, idx, 4'hc, 1'b0, 1'b1);
      ex(OP_DECIMAL_ADJUST_ADD, 1'b1, 1'b0, 12'h0aa);
      look(12'h012, idx, 4'hc, 1'b0, 1'b0);
      ex(OP_INDEX_COMPARE_SKIP, 1'b0, 1'b0, {4'h0, ~idx[7:0]});
      ex(OP_DECIMAL_ADJUST_ADD, 1'b0, 1'b0, 12'h000);
      look(12'h014, idx, 4'h2, 1'b1, 1'b0);
      foreach (tab[i]) begin
         put(12'h020, 12'h000, tab[i][15:12], tab[i][8]);
         ex(tab[i][16] ? OP_DECIMAL_ADJUST_SUB : OP_DECIMAL_ADJUST_ADD, 1'b0, 1'b0, 12'h000);
         look(12'h021, 12'h000, tab[i][7:4], tab[i][0], 1'b0);
      end
      put(12'h030, 12'h5ff, 4'hb, 1'b0);
      wr_q.push_back({12'h0c7, 4'h1});
      ex(OP_DECIMAL_ADJUST_ADD, 1'b1, 1'b0, 12'h0c7);
      wr_q.push_back({12'h5ff, 4'h7});
      ex(OP_DECIMAL_ADJUST_ADD, 1'b1, 1'b1, 12'h0c7);
      wr_q.push_back({12'h500, 4'h7});
      ex(OP_DECIMAL_ADJUST_SUB, 1'b1, 1'b1, 12'h0c7);
      look(12'h033, 12'h501, 4'h7, 1'b1, 1'b0);
      for (int k = 0; k < 16; k++) begin
         lfsr = step(lfsr);
         a = (k == 12 || k == 13) ? 4'h0 : lfsr[3:0];
         c = lfsr[4];
         pc = {lfsr[5], lfsr[16:6]};
         put(pc, 12'h000, a, c);
         case (k % 8)
            0, 1, 2, 3: tk = a[k % 4];
            4: tk = (a != 4'h0);
            5: tk = (a == 4'h0);
            6: tk = !c;
            default: tk = c;
         endcase
         ex(idb_op_t'(7 + k % 8), 1'b0, 1'b0, lfsr[27:16]);
         look(tk ? {pc[11], lfsr[26:16]} : pc + 12'h001, 12'h000, a, c, 1'b0);
      end
      put(12'h812, 12'h000, 4'h0, 1'b0);
      ex(OP_JUMP_FAR, 1'b0, 1'b0, 12'h345);
      look(12'h345, 12'h000, 4'h0, 1'b0, 1'b0);
      pc = 12'h345;
      for (int k = 0; k < 8; k++) begin
         ret_pc[k] = pc + 12'h001;
         pc = {~pc[11], pc[10:0] + 11'h101};
         ex(OP_CALL, 1'b0, 1'b0, pc);
      end
      look(pc, 12'h000, 4'h0, 1'b0, 1'b0);
      rd(`IDB_ADDR_STATUS, 32'h8);
      for (int k = 7; k >= 0; k--) begin
         ex(OP_RETURN, 1'b0, 1'b0, 12'h000);
         look(ret_pc[k], 12'h000, 4'h0, 1'b0, 1'b0);
      end
      rd(`IDB_ADDR_STATUS, 32'h0);
      give_verdict();
   end
endmodule
